// >>> design/usb_misc_test_lock_regs.sv
// scratch, write-unlock and line test registers on the parallel register port
// Functional notes
// - 16-bit read/write scratch, no hardware effect, cleared by chip and bus reset
// - powered flag low and suspend entered: block every register write except the unlock key write
// - writing AA37h to write-only unlock register re-enables writes after resume
// - powered flag high: suspend never locks writes, no unlock needed
// - bit 7 forces high-speed only and disables chirp detection
// - bit 4 forces full-speed only and disables chirp detection
// - bit 3 toggles DP and DM in a fixed pseudo-random pattern
// - bit 2 drives K state, bit 1 drives J state
// - bit 0 sets high-speed idle, answer only valid HS IN tokens with NAK
// - a line test mode (bits 3:0) once entered persists until power cycle; bits 7 and 4 stay writable
`timescale 1ns/1ps
`include "usb_misc_map.svh"
module usb_misc_test_lock_regs
  import usb_misc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              bus_reset_in,
  input  wire logic              suspend_in,
  input  wire logic              processor_powered_flag_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [15:0]       reg_wdata_in,
  input  wire logic              bus_write_strobe_in,
  input  wire logic              reg_read_in,
  output logic [15:0]            reg_rdata_out,
  output logic                   write_locked_out,
  output logic                   write_enable_out,
  output logic                   force_high_speed_out,
  output logic                   force_full_speed_out,
  output logic                   chirp_disable_out,
  output logic                   hs_nak_only_out,
  output logic                   line_dp_out,
  output logic                   line_dm_out,
  output logic                   line_drive_out,
  output line_mode_t             line_mode_out,
  output logic                   test_mode_active_out
);
  logic [15:0] firmware_scratch_reg;
  logic [7:0]  line_test_control_reg;
  logic        write_locked_reg;
  logic        suspend_prev_reg;
  logic        test_latched_reg;
  line_mode_t  line_mode_reg;
  line_mode_t  line_mode_next;
  logic        wr_ok;
  logic        unlock_hit;
  logic        pattern_bit;

  // the unlock register itself must stay writable or the lock could never be lifted
  assign unlock_hit = bus_write_strobe_in && reg_addr_in == `ADDR_WRITE_UNLOCK_KEY
                      && reg_wdata_in == `UNLOCK_KEY_VALUE;
  assign wr_ok      = bus_write_strobe_in && !write_locked_reg;

  // lock taken on the suspend entry edge only when the processor is unpowered
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      suspend_prev_reg <= 1'b0;
    else
      suspend_prev_reg <= suspend_in;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      write_locked_reg <= 1'b0;
    else if (suspend_in && !suspend_prev_reg && !processor_powered_flag_in)
      write_locked_reg <= 1'b1;
    else if (unlock_hit && !suspend_in)
      write_locked_reg <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      firmware_scratch_reg <= `SCRATCH_RESET;
    else if (bus_reset_in)
      firmware_scratch_reg <= `SCRATCH_RESET;
    else if (wr_ok && reg_addr_in == `ADDR_FIRMWARE_SCRATCH)
      firmware_scratch_reg <= reg_wdata_in;
  end

  // reserved bits 6:5 are never stored and read back as zero
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      line_test_control_reg <= `TEST_CONTROL_RESET;
    else if (bus_reset_in)
      line_test_control_reg <= line_test_control_reg & `TEST_SPEED_BITS_MASK;
    else if (wr_ok && reg_addr_in == `ADDR_LINE_TEST_CONTROL)
      line_test_control_reg <= reg_wdata_in[7:0] & `TEST_CONTROL_MASK;
  end

  // line mode priority resolves illegal multi-bit settings deterministically
  always_comb
  begin
    line_mode_next = LINE_NORMAL;
    if (line_test_control_reg[`BIT_PATTERN_TOGGLE])
      line_mode_next = LINE_PATTERN;
    else if (line_test_control_reg[`BIT_K_DRIVE])
      line_mode_next = LINE_K;
    else if (line_test_control_reg[`BIT_J_DRIVE])
      line_mode_next = LINE_J;
    else if (line_test_control_reg[`BIT_QUIESCENT_NAK])
      line_mode_next = LINE_QUIET;
  end

  // the first line mode entered is held; clearing or rewriting the bits cannot leave it
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      line_mode_reg    <= LINE_NORMAL;
      test_latched_reg <= 1'b0;
    end
    else if (!test_latched_reg && line_mode_next != LINE_NORMAL)
    begin
      line_mode_reg    <= line_mode_next;
      test_latched_reg <= 1'b1;
    end
  end

  pattern_gen u_pattern
  (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .enable_in   (line_mode_reg == LINE_PATTERN),
    .bit_out     (pattern_bit)
  );

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      line_dp_out    <= 1'b0;
      line_dm_out    <= 1'b0;
      line_drive_out <= 1'b0;
    end
    else
    begin
      unique case (line_mode_reg)
        LINE_PATTERN:
        begin
          line_dp_out    <= pattern_bit;
          line_dm_out    <= !pattern_bit;
          line_drive_out <= 1'b1;
        end
        LINE_K:
        begin
          line_dp_out    <= 1'b0;
          line_dm_out    <= 1'b1;
          line_drive_out <= 1'b1;
        end
        LINE_J:
        begin
          line_dp_out    <= 1'b1;
          line_dm_out    <= 1'b0;
          line_drive_out <= 1'b1;
        end
        LINE_QUIET:
        begin
          line_dp_out    <= 1'b0;
          line_dm_out    <= 1'b0;
          line_drive_out <= 1'b1;
        end
        default:
        begin
          line_dp_out    <= 1'b0;
          line_dm_out    <= 1'b0;
          line_drive_out <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= `READ_DEFAULT;
    else if (reg_read_in)
    begin
      unique case (reg_addr_in)
        `ADDR_FIRMWARE_SCRATCH:  reg_rdata_out <= firmware_scratch_reg;
        `ADDR_LINE_TEST_CONTROL: reg_rdata_out <= {8'h00, line_test_control_reg};
        default:                 reg_rdata_out <= `READ_DEFAULT;
      endcase
    end
  end

  assign force_high_speed_out = line_test_control_reg[`BIT_FORCE_HIGH_SPEED];
  assign force_full_speed_out = line_test_control_reg[`BIT_FORCE_FULL_SPEED];
  assign chirp_disable_out    = force_high_speed_out | force_full_speed_out;
  assign hs_nak_only_out      = line_mode_reg == LINE_QUIET;
  assign write_locked_out     = write_locked_reg;
  assign write_enable_out     = wr_ok;
  assign line_mode_out        = line_mode_reg;
  assign test_mode_active_out = test_latched_reg;

  chk_lock_on_suspend: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    suspend_in && !$past(suspend_in) && !processor_powered_flag_in |=> write_locked_out)
    else $error("write lock not taken on unpowered suspend");
  chk_powered_no_lock: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !write_locked_out && processor_powered_flag_in |=> !write_locked_out)
    else $error("write lock taken while processor powered");
  chk_unlock_clears: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    unlock_hit && !suspend_in && !(suspend_in && !suspend_prev_reg) |=> !write_locked_out)
    else $error("unlock code did not clear lock");
  chk_locked_scratch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    write_locked_out && !bus_reset_in |=> $stable(firmware_scratch_reg))
    else $error("scratch changed while locked");
  chk_scratch_busrst: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    bus_reset_in |=> firmware_scratch_reg == `SCRATCH_RESET)
    else $error("scratch not cleared by bus reset");
  chk_busrst_speed: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    bus_reset_in |=> (line_test_control_reg & `TEST_LINE_BITS_MASK) == `TEST_CONTROL_RESET &&
      $stable(line_test_control_reg & `TEST_SPEED_BITS_MASK))
    else $error("bus reset handling of test bits wrong");
  chk_chirp_off: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    line_test_control_reg[`BIT_FORCE_HIGH_SPEED] || line_test_control_reg[`BIT_FORCE_FULL_SPEED]
      |-> chirp_disable_out)
    else $error("chirp detection not disabled");
  chk_k_drive_bit_drive: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    line_mode_out == LINE_K |=> line_drive_out && !line_dp_out && line_dm_out)
    else $error("k state not driven");
  chk_mode_sticky: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    test_mode_active_out |=> test_mode_active_out && $stable(line_mode_out))
    else $error("test mode left without power cycle");
endmodule

// >>> design/usb_misc_map.svh
// register offsets, field positions, reset values and codes for the misc/test register bank
`ifndef USB_MISC_MAP_SVH
`define USB_MISC_MAP_SVH
`define ADDR_FIRMWARE_SCRATCH  8'h78
`define ADDR_WRITE_UNLOCK_KEY  8'h7C
`define ADDR_LINE_TEST_CONTROL 8'h84
`define UNLOCK_KEY_VALUE       16'hAA37
`define SCRATCH_RESET          16'h0000
`define READ_DEFAULT           16'h0000
`define TEST_CONTROL_RESET     8'h00
`define TEST_CONTROL_MASK      8'h9F
`define TEST_LINE_BITS_MASK    8'h0F
`define TEST_SPEED_BITS_MASK   8'h90
`define BIT_FORCE_HIGH_SPEED   7
`define BIT_FORCE_FULL_SPEED   4
`define BIT_PATTERN_TOGGLE     3
`define BIT_K_DRIVE            2
`define BIT_J_DRIVE            1
`define BIT_QUIESCENT_NAK      0
`define PATTERN_SEED           9'h1FF
`define PATTERN_TAP_A          8
`define PATTERN_TAP_B          4
`endif

// >>> design/usb_misc_pkg.sv
// types shared by the misc/test register bank
package usb_misc_pkg;
  typedef enum logic [2:0]
  {
    LINE_NORMAL  = 3'b000,
    LINE_PATTERN = 3'b001,
    LINE_K       = 3'b010,
    LINE_J       = 3'b011,
    LINE_QUIET   = 3'b100
  } line_mode_t;
endpackage

// >>> design/pattern_gen.sv
// pseudo-random bit source for the line pattern test, stepping only while enabled
`timescale 1ns/1ps
`include "usb_misc_map.svh"
module pattern_gen
(
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic enable_in,
  output logic      bit_out
);
  logic [8:0] lfsr_reg;

  // fixed seed so the pattern is the same each time the test starts
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      lfsr_reg <= `PATTERN_SEED;
    else if (enable_in)
      lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[`PATTERN_TAP_A] ^ lfsr_reg[`PATTERN_TAP_B]};
  end

  assign bit_out = lfsr_reg[8];
endmodule

// >>> verif/mcu_model.sv
// processor model that drives the parallel register port
`timescale 1ns/1ps
module mcu_model
(
  input  wire logic  core_clk_in,
  output logic [7:0]  reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic        bus_write_strobe_out,
  output logic        reg_read_out
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    bus_write_strobe_out = 1'b0;
    reg_read_out = 1'b0;
  end
  // released lines show the inverse, never a stale value that could pass by luck
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    bus_write_strobe_out = 1'b1;
    @(negedge core_clk_in);
    bus_write_strobe_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_read_out = 1'b1;
    @(negedge core_clk_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~a;
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the misc/test register bank
`timescale 1ns/1ps
module testbench
  import usb_misc_pkg::*;
;
  logic        core_clk, reset_n, bus_reset, suspend, powered, wstrobe, rd, rd_seen;
  logic        dp, dm, drv, locked, fhs, ffs, chirp, nak, active, wen, wen_last;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, r;
  logic [15:0] exp_q[$];
  line_mode_t  mode;
  line_mode_t  modes[3] = '{LINE_PATTERN, LINE_J, LINE_QUIET};
  int          bitpos[3] = '{3, 1, 0};
  int          n_fail, compares, cycles, ones;

  mcu_model i_mcu_model (.core_clk_in(core_clk), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .bus_write_strobe_out(wstrobe), .reg_read_out(rd));
  usb_misc_test_lock_regs i_usb_misc_test_lock_regs (.core_clk_in(core_clk),
    .reset_n_in(reset_n), .bus_reset_in(bus_reset), .suspend_in(suspend),
    .processor_powered_flag_in(powered), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .bus_write_strobe_in(wstrobe), .reg_read_in(rd), .reg_rdata_out(rdata),
    .write_locked_out(locked), .write_enable_out(wen), .force_high_speed_out(fhs),
    .force_full_speed_out(ffs), .chirp_disable_out(chirp), .hs_nak_only_out(nak),
    .line_dp_out(dp), .line_dm_out(dm), .line_drive_out(drv), .line_mode_out(mode),
    .test_mode_active_out(active));

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_out(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(logic [15:0] e, logic [15:0] g);
    chk_out("rdata", e, g);
  endtask
  task automatic gap(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    i_mcu_model.wr(a, d);
  endtask
  // the note goes on the queue before the read is issued
  task automatic rdx(logic [7:0] a, logic [15:0] e);
    exp_q.push_back(e);
    i_mcu_model.rd(a);
  endtask
  task automatic chip_reset();
    @(negedge core_clk);
    reset_n = 1'b0;
    gap(2);
    reset_n = 1'b1;
  endtask

  // read data stands until the next read, so the falling edge sees it settled
  always @(posedge core_clk)
    rd_seen <= rd && reset_n;
  // write gate as the design saw it at the strobe edge
  always @(posedge core_clk)
    if (wstrobe)
      wen_last <= wen;
  always @(negedge core_clk)
    if (rd_seen)
      chk_rd(exp_q.pop_front(), rdata);
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    reset_n = 1'b0;
    bus_reset = 1'b0;
    suspend = 1'b0;
    powered = 1'b0;
    void'($urandom(32'h2a93));
    chip_reset();
    rdx(8'h78, 16'h0000);
    rdx(8'h84, 16'h0000);
    rdx(8'h7C, 16'h0000);
    r = 16'($urandom);
    wr(8'h78, r);
    rdx(8'h78, r);
    wr(8'hFF & 8'h84, 16'hFFE4);
    gap(2);
    rdx(8'h84, 16'h0084);
    chk_out("hs", 1, fhs);
    chk_out("chirp", 1, chirp);
    chk_out("mode", LINE_K, mode);
    chk_out("kline", 3'b011, {dp, dm, drv});
    chk_out("active", 1, active);
    @(negedge core_clk);
    bus_reset = 1'b1;
    gap(1);
    bus_reset = 1'b0;
    rdx(8'h78, 16'h0000);
    rdx(8'h84, 16'h0080);
    wr(8'h84, 16'h0000);
    gap(2);
    chk_out("mode", LINE_K, mode);
    for (int i = 0; i < 3; i++)
    begin
      chip_reset();
      wr(8'h84, 16'h0010 | (16'h0001 << bitpos[i]));
      gap(2);
      chk_out("fs", 1, ffs);
      chk_out("chirp", 1, chirp);
      chk_out("mode", modes[i], mode);
      chk_out("nak", i == 2, nak);
      chk_out("diff", i < 2, dp ^ dm);
      if (i == 1)
        chk_out("jline", 3'b101, {dp, dm, drv});
      ones = 0;
      for (int k = 0; k < 40 && i == 0; k++)
      begin
        @(negedge core_clk);
        ones += dp;
      end
      if (i == 0)
        chk_out("toggle", 1, ones > 0 && ones < 40);
    end
    chk_out("qline", 3'b001, {dp, dm, drv});
    chip_reset();
    suspend = 1'b1;
    gap(1);
    chk_out("lock", 1, locked);
    wr(8'h78, 16'h1234);
    chk_out("wen", 0, wen_last);
    suspend = 1'b0;
    wr(8'h7C, 16'hAA36);
    wr(8'h78, 16'h4321);
    rdx(8'h78, 16'h0000);
    chk_out("lock", 1, locked);
    wr(8'h7C, 16'hAA37);
    gap(1);
    chk_out("lock", 0, locked);
    wr(8'h78, 16'h5A5A);
    chk_out("wen", 1, wen_last);
    rdx(8'h78, 16'h5A5A);
    powered = 1'b1;
    suspend = 1'b1;
    gap(1);
    chk_out("lock", 0, locked);
    wr(8'h78, 16'hA5A5);
    chk_out("wen", 1, wen_last);
    rdx(8'h78, 16'hA5A5);
    gap(2);
    stop_test();
  end
endmodule
